// ==== core/gbcd_decoder.sv ====
`timescale 1ns/1ps
module gbcd_decoder #(
  parameter bit TRIG_UNADDR = 1'b1
) (
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire logic                        atn_n,
  input  wire logic                        ifc_n,
  input  wire logic                        ren_n,
  input  wire logic                        eoi_n_i,
  output logic                             eoi_n_o,
  output logic                             eoi_oe,
  input  wire logic                        dav_n_i,
  output logic                             dav_n_o,
  output logic                             dav_oe,
  input  wire logic                        nrfd_n_i,
  output logic                             nrfd_n_o,
  output logic                             nrfd_oe,
  input  wire logic                        ndac_n_i,
  output logic                             ndac_n_o,
  output logic                             ndac_oe,
  input  wire logic [gbcd_pkg::DIO_W-1:0]  dio_n_i,
  output logic      [gbcd_pkg::DIO_W-1:0]  dio_n_o,
  output logic      [gbcd_pkg::DIO_W-1:0]  dio_oe,
  output logic                             srq_n_o,
  output logic                             srq_oe,
  input  wire logic [gbcd_pkg::PA_W-1:0]   prim_addr,
  input  wire logic                        lock_cfg,
  input  wire logic                        local_key,
  input  wire logic                        svc_req,
  input  wire logic [gbcd_pkg::DIO_W-1:0]  status_byte,
  input  wire logic                        tx_valid,
  input  wire logic [gbcd_pkg::DIO_W-1:0]  tx_data,
  input  wire logic                        tx_last,
  output logic                             tx_ready,
  output logic                             rx_valid,
  output logic      [gbcd_pkg::DIO_W-1:0]  rx_data,
  output logic                             rx_end,
  input  wire logic                        rx_ready,
  output logic                             remote,
  output logic                             lockout,
  output logic                             panel_locked,
  output logic                             listener,
  output logic                             talker,
  output logic                             spoll_mode,
  output logic                             dev_clear,
  output logic                             trigger
);
  logic [gbcd_pkg::PINS_W-1:0] pins_s;
  gbcd_pkg::gbcd_pins_t        bus;
  gbcd_pkg::gbcd_byte_t        acc_out;
  logic                        acc_valid;
  logic                        acc_ready;
  logic                        cmd_fire;
  logic [6:0]                  cmd;
  logic [6:0]                  my_lad;
  logic [6:0]                  my_tad;
  logic                        ren_q;
  logic                        svc_q;
  logic                        srq_pend;
  logic                        sb_sent;
  logic                        sb_done;
  logic                        talk_en;
  gbcd_pkg::gbcd_sh_t          sh;
  logic                        sh_sb;
  logic [gbcd_pkg::DIO_W-1:0]  dio_q;
  logic                        eoi_q;
  logic                        next_listener;
  logic                        next_talker;
  logic                        next_remote;
  logic                        next_lockout;
  logic                        next_spoll;
  logic                        next_ren_q;
  logic                        next_svc_q;
  logic                        next_srq_pend;
  logic                        next_sb_sent;
  logic                        next_dev_clear;
  logic                        next_trigger;
  gbcd_pkg::gbcd_sh_t          next_sh;
  logic                        next_sh_sb;
  logic [gbcd_pkg::DIO_W-1:0]  next_dio_q;
  logic                        next_eoi_q;

  // ATN, IFC and REN are inputs only; this end never drives them
  gbcd_sync #(.W(gbcd_pkg::PINS_W)) i_gbcd_sync (
    .clk  (clk),
    .srst (srst),
    .d    ({atn_n, ifc_n, ren_n, eoi_n_i, dav_n_i, nrfd_n_i, ndac_n_i,
            dio_n_i}),
    .q    (pins_s)
  );

  // Low level is true on every line
  assign bus = gbcd_pkg::gbcd_pins_t'(~pins_s);

  // Commands are always taken at once so the controller never stalls
  assign acc_ready = acc_out.atn | rx_ready;

  gbcd_acceptor i_gbcd_acceptor (
    .clk       (clk),
    .srst      (srst),
    .bus       (bus),
    .active    (bus.atn | listener),
    .nrfd_oe   (nrfd_oe),
    .ndac_oe   (ndac_oe),
    .out_valid (acc_valid),
    .out       (acc_out),
    .out_ready (acc_ready)
  );

  // Open-drain: a line is pulled low only by its enable
  assign nrfd_n_o = 1'b0;
  assign ndac_n_o = 1'b0;
  assign dav_n_o  = 1'b0;
  assign eoi_n_o  = 1'b0;
  assign srq_n_o  = 1'b0;
  assign dio_n_o  = '0;
  assign srq_oe   = srq_pend;

  // Data bytes pass to the parser
  assign rx_valid = acc_valid & ~acc_out.atn;
  assign rx_data  = acc_out.data;
  assign rx_end   = acc_out.eoi;

  assign cmd_fire = acc_valid & acc_out.atn;
  assign cmd      = acc_out.data[6:0];
  assign my_lad   = gbcd_pkg::LAG_BASE | {2'h0, prim_addr};
  assign my_tad   = gbcd_pkg::TAG_BASE | {2'h0, prim_addr};

  // Lockout only freezes the panel while remote
  assign panel_locked = remote & (lockout | lock_cfg);
  assign talk_en      = talker & ~bus.atn;
  assign tx_ready     = (sh == gbcd_pkg::SH_IDLE) & talk_en & ~spoll_mode;
  assign sb_done      = (sh == gbcd_pkg::SH_REL) & sh_sb;

  always_comb begin
    next_listener  = listener;
    next_talker    = talker;
    next_remote    = remote;
    next_lockout   = lockout;
    next_spoll     = spoll_mode;
    next_sb_sent   = sb_sent;
    next_srq_pend  = srq_pend;
    next_dev_clear = 1'b0;
    next_trigger   = 1'b0;
    next_ren_q     = bus.ren;
    next_svc_q     = svc_req;
    if (bus.ren && !ren_q) next_remote = 1'b1;
    if (local_key && !lockout) next_remote = 1'b0;
    if (cmd_fire) begin
      // UNL first: it must win if address 31 is ever configured
      if (cmd == gbcd_pkg::CMD_UNL) begin
        next_listener = 1'b0;
      end else if (cmd == my_lad) begin
        next_listener = 1'b1;
        if (bus.ren) next_remote = 1'b1;
      end else if (cmd == gbcd_pkg::CMD_UNT) begin
        next_talker = 1'b0;
      end else if (cmd == my_tad) begin
        next_talker  = 1'b1;
        next_sb_sent = 1'b0;
      end else if (cmd[6:5] == gbcd_pkg::GRP_TAG) begin
        next_talker = 1'b0;
      end else if (cmd[6:5] == gbcd_pkg::GRP_SCG) begin
        next_talker = talker;
      end else if (cmd == gbcd_pkg::CMD_LLO) begin
        next_lockout = 1'b1;
      end else if (cmd == gbcd_pkg::CMD_DCL) begin
        next_dev_clear = 1'b1;
      end else if (cmd == gbcd_pkg::CMD_SPE) begin
        next_spoll = 1'b1;
      end else if (cmd == gbcd_pkg::CMD_SPD) begin
        next_spoll = 1'b0;
      end else if (listener) begin
        // SDC and GTL act only once our listen address came
        if (cmd == gbcd_pkg::CMD_SDC) next_dev_clear = 1'b1;
        if (cmd == gbcd_pkg::CMD_GTL) next_remote = 1'b0;
      end
      if (cmd == gbcd_pkg::CMD_GET && (listener || TRIG_UNADDR)) begin
        next_trigger = 1'b1;
      end
    end
    if (sb_done) begin
      next_sb_sent  = 1'b1;
      next_srq_pend = 1'b0;
    end
    // A new request in the clearing cycle is kept
    if (svc_req && !svc_q) next_srq_pend = 1'b1;
    if (!bus.ren) begin
      next_remote  = 1'b0;
      next_lockout = 1'b0;
    end
    if (bus.ifc) begin
      next_listener = 1'b0;
      next_talker   = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      listener   <= 1'b0;
      talker     <= 1'b0;
      remote     <= 1'b0;
      lockout    <= 1'b0;
      spoll_mode <= 1'b0;
      sb_sent    <= 1'b0;
      srq_pend   <= 1'b0;
      dev_clear  <= 1'b0;
      trigger    <= 1'b0;
      ren_q      <= 1'b0;
      svc_q      <= 1'b0;
    end else begin
      listener   <= next_listener;
      talker     <= next_talker;
      remote     <= next_remote;
      lockout    <= next_lockout;
      spoll_mode <= next_spoll;
      sb_sent    <= next_sb_sent;
      srq_pend   <= next_srq_pend;
      dev_clear  <= next_dev_clear;
      trigger    <= next_trigger;
      ren_q      <= next_ren_q;
      svc_q      <= next_svc_q;
    end
  end

  // Source handshake; ATN aborts any byte in flight
  always_comb begin
    next_sh    = sh;
    next_sh_sb = sh_sb;
    next_dio_q = dio_q;
    next_eoi_q = eoi_q;
    unique case (sh)
      gbcd_pkg::SH_IDLE: begin
        if (talk_en && spoll_mode && !sb_sent) begin
          next_dio_q = status_byte;
          next_dio_q[gbcd_pkg::RQS_BIT] = srq_pend;
          next_eoi_q = 1'b0;
          next_sh_sb = 1'b1;
          next_sh    = gbcd_pkg::SH_SETUP;
        end else if (tx_ready && tx_valid) begin
          next_dio_q = tx_data;
          next_eoi_q = tx_last;
          next_sh_sb = 1'b0;
          next_sh    = gbcd_pkg::SH_SETUP;
        end
      end
      gbcd_pkg::SH_SETUP: begin
        if (!talk_en) next_sh = gbcd_pkg::SH_IDLE;
        else if (!bus.nrfd && bus.ndac) next_sh = gbcd_pkg::SH_DAV;
      end
      gbcd_pkg::SH_DAV: begin
        if (!talk_en) next_sh = gbcd_pkg::SH_IDLE;
        else if (!bus.ndac) next_sh = gbcd_pkg::SH_REL;
      end
      gbcd_pkg::SH_REL: next_sh = gbcd_pkg::SH_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sh     <= gbcd_pkg::SH_IDLE;
      sh_sb  <= 1'b0;
      dio_q  <= '0;
      eoi_q  <= 1'b0;
      dio_oe <= '0;
      dav_oe <= 1'b0;
      eoi_oe <= 1'b0;
    end else begin
      sh     <= next_sh;
      sh_sb  <= next_sh_sb;
      dio_q  <= next_dio_q;
      eoi_q  <= next_eoi_q;
      dio_oe <= (next_sh == gbcd_pkg::SH_SETUP || next_sh == gbcd_pkg::SH_DAV)
                ? next_dio_q : '0;
      dav_oe <= (next_sh == gbcd_pkg::SH_DAV);
      eoi_oe <= (next_sh == gbcd_pkg::SH_SETUP || next_sh == gbcd_pkg::SH_DAV)
                & next_eoi_q;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_mla;
    cmd_fire && cmd == my_lad && !bus.ifc && my_lad != gbcd_pkg::CMD_UNL
      |=> listener;
  endproperty
  a_mla: assert property (p_mla)
    else $error("Own listen address did not make listener");

  property p_mta;
    cmd_fire && cmd == my_tad && !bus.ifc |=> talker;
  endproperty
  a_mta: assert property (p_mta)
    else $error("Own talk address did not make talker");

  property p_unl;
    cmd_fire && cmd == gbcd_pkg::CMD_UNL |=> !listener;
  endproperty
  a_unl: assert property (p_unl)
    else $error("UNL left listener active");

  property p_unt;
    cmd_fire && cmd == gbcd_pkg::CMD_UNT |=> !talker;
  endproperty
  a_unt: assert property (p_unt)
    else $error("UNT left talker active");

  property p_ifc;
    bus.ifc |=> !listener && !talker;
  endproperty
  a_ifc: assert property (p_ifc)
    else $error("IFC did not idle talker and listener");

  property p_sdc_unaddr;
    cmd_fire && cmd == gbcd_pkg::CMD_SDC && !listener |=> !dev_clear;
  endproperty
  a_sdc_unaddr: assert property (p_sdc_unaddr)
    else $error("SDC acted while not addressed");

  property p_dcl;
    cmd_fire && cmd == gbcd_pkg::CMD_DCL |=> dev_clear ##1 !dev_clear;
  endproperty
  a_dcl: assert property (p_dcl)
    else $error("DCL did not give one clear pulse");

  property p_llo;
    cmd_fire && cmd == gbcd_pkg::CMD_LLO && bus.ren |=> lockout;
  endproperty
  a_llo: assert property (p_llo)
    else $error("LLO did not lock out");

  property p_spe;
    cmd_fire && cmd == gbcd_pkg::CMD_SPE |=> spoll_mode;
  endproperty
  a_spe: assert property (p_spe)
    else $error("SPE did not enter serial poll");

  property p_srq_hold;
    srq_oe && !sb_done |=> srq_oe;
  endproperty
  a_srq_hold: assert property (p_srq_hold)
    else $error("SRQ dropped before service");

  property p_cmd_not_data;
    acc_valid && acc_out.atn |-> !rx_valid;
  endproperty
  a_cmd_not_data: assert property (p_cmd_not_data)
    else $error("Command byte passed as data");

  property p_dav_ready;
    $rose(dav_oe) |-> $past(!bus.nrfd && bus.ndac);
  endproperty
  a_dav_ready: assert property (p_dav_ready)
    else $error("DAV asserted before listeners ready");

  c_listen_data: cover property (listener && rx_valid && rx_end);
  c_serial_poll: cover property (spoll_mode && sb_done);
  c_sdc_clear: cover property (listener && cmd_fire
                               && cmd == gbcd_pkg::CMD_SDC ##1 dev_clear);
  c_talk_last: cover property (eoi_oe && dav_oe);
endmodule // gbcd_decoder

// ==== core/gbcd_pkg.sv ====
package gbcd_pkg;

  // Primary address width and range
  localparam int          PA_W     = 5;
  localparam logic [4:0]  PA_MAX   = 5'h1F;

  // Multiline command codes, DIO8 is ignored
  localparam logic [6:0]  CMD_GTL  = 7'h01;
  localparam logic [6:0]  CMD_SDC  = 7'h04;
  localparam logic [6:0]  CMD_GET  = 7'h08;
  localparam logic [6:0]  CMD_LLO  = 7'h11;
  localparam logic [6:0]  CMD_DCL  = 7'h14;
  localparam logic [6:0]  CMD_SPE  = 7'h18;
  localparam logic [6:0]  CMD_SPD  = 7'h19;
  localparam logic [6:0]  CMD_UNL  = 7'h3F;
  localparam logic [6:0]  CMD_UNT  = 7'h5F;

  // Address groups
  localparam logic [6:0]  LAG_BASE = 7'h20;
  localparam logic [6:0]  TAG_BASE = 7'h40;
  localparam logic [1:0]  GRP_TAG  = 2'h2;
  localparam logic [1:0]  GRP_SCG  = 2'h3;

  // Status byte bit that reports a pending service request
  localparam int          RQS_BIT  = 6;

  // Synchroniser depth and bus width
  localparam int          SYNC_N   = 2;
  localparam int          DIO_W    = 8;
  localparam int          PINS_W   = 15;

  // Bus lines at their logical (true high) level
  typedef struct packed {
    logic             atn;
    logic             ifc;
    logic             ren;
    logic             eoi;
    logic             dav;
    logic             nrfd;
    logic             ndac;
    logic [DIO_W-1:0] dio;
  } gbcd_pins_t;

  // One accepted byte with the line states sampled at acceptance
  typedef struct packed {
    logic [DIO_W-1:0] data;
    logic             atn;
    logic             eoi;
  } gbcd_byte_t;

  typedef enum logic [1:0] {AH_RDY, AH_HOLD, AH_DONE} gbcd_ah_t;
  typedef enum logic [1:0] {SH_IDLE, SH_SETUP, SH_DAV, SH_REL} gbcd_sh_t;

endpackage

// ==== core/gbcd_sync.sv ====
`timescale 1ns/1ps
module gbcd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  // Pins idle high (false); reset to that level
  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta <= '1;
      q    <= '1;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // gbcd_sync

// ==== core/gbcd_acceptor.sv ====
`timescale 1ns/1ps
module gbcd_acceptor (
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire gbcd_pkg::gbcd_pins_t bus,
  input  wire logic                active,
  output logic                     nrfd_oe,
  output logic                     ndac_oe,
  output logic                     out_valid,
  output gbcd_pkg::gbcd_byte_t     out,
  input  wire logic                out_ready
);
  gbcd_pkg::gbcd_ah_t   st;
  gbcd_pkg::gbcd_ah_t   next_st;
  gbcd_pkg::gbcd_byte_t next_out;
  logic                 next_nrfd_oe;
  logic                 next_ndac_oe;

  assign out_valid = (st == gbcd_pkg::AH_HOLD);

  always_comb begin
    next_st  = st;
    next_out = out;
    unique case (st)
      gbcd_pkg::AH_RDY: begin
        if (active && bus.dav) begin
          // ATN is caught with the byte itself
          next_out = '{data: bus.dio, atn: bus.atn, eoi: bus.eoi};
          next_st  = gbcd_pkg::AH_HOLD;
        end
      end
      gbcd_pkg::AH_HOLD: begin
        // NDAC stays low until the byte is taken
        if (out_ready) next_st = gbcd_pkg::AH_DONE;
      end
      gbcd_pkg::AH_DONE: begin
        if (!bus.dav) next_st = gbcd_pkg::AH_RDY;
      end
    endcase
    // Idle acceptors let others run the handshake
    next_nrfd_oe = (next_st != gbcd_pkg::AH_RDY);
    next_ndac_oe = (next_st == gbcd_pkg::AH_HOLD)
                 || (next_st == gbcd_pkg::AH_RDY && active);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st      <= gbcd_pkg::AH_RDY;
      out     <= '0;
      nrfd_oe <= 1'b0;
      ndac_oe <= 1'b0;
    end else begin
      st      <= next_st;
      out     <= next_out;
      nrfd_oe <= next_nrfd_oe;
      ndac_oe <= next_ndac_oe;
    end
  end

  property p_ndac_after_dav;
    @(posedge clk) disable iff (srst)
    // NDAC also drops when the acceptor goes idle; only a hand-off needs DAV
    $fell(ndac_oe) && nrfd_oe |-> $past(bus.dav);
  endproperty
  a_ndac_after_dav: assert property (p_ndac_after_dav)
    else $error("NDAC released without data valid");

  property p_hold_not_ready;
    @(posedge clk) disable iff (srst)
    out_valid |-> ##1 nrfd_oe [*2];
  endproperty
  a_hold_not_ready: assert property (p_hold_not_ready)
    else $error("NRFD released while a byte is pending");
endmodule // gbcd_acceptor

// ==== test/gbcd_ctrl_model.sv ====
`timescale 1ns/1ps
module gbcd_ctrl_model (
  input  wire logic       clk,
  input  wire logic       eoi_oe,
  input  wire logic       dav_oe,
  input  wire logic       nrfd_oe,
  input  wire logic       ndac_oe,
  input  wire logic       srq_oe,
  input  wire logic [7:0] dio_oe,
  output logic            atn_n,
  output logic            ifc_n,
  output logic            ren_n,
  output logic            eoi_n,
  output logic            dav_n,
  output logic            nrfd_n,
  output logic            ndac_n,
  output logic            srq_n,
  output logic      [7:0] dio_n
);
  logic       atn, ifc, ren, eoi, dav, nrfd, ndac;
  logic [7:0] dio;
  int         stalls;
  // Released lines float high on their pull-ups
  assign atn_n  = ~atn;
  assign ifc_n  = ~ifc;
  assign ren_n  = ~ren;
  assign eoi_n  = ~(eoi | eoi_oe);
  assign dav_n  = ~(dav | dav_oe);
  assign nrfd_n = ~(nrfd | nrfd_oe);
  assign ndac_n = ~(ndac | ndac_oe);
  assign srq_n  = ~srq_oe;
  assign dio_n  = ~(dio | dio_oe);
  initial begin
    {atn, ifc, ren, eoi, dav, nrfd, ndac} = '0;
    dio = 8'h00;
    stalls = 0;
  end
  // Act just after the edge so raw pins have settled
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  // Source side; data settles a cycle ahead of DAV
  task automatic send(input logic [7:0] b, input logic last);
    int n;
    step();
    dio = b;
    eoi = last;
    step();
    for (n = 0; n < 400 && !(nrfd_n && !ndac_n); n++) step();
    stalls += int'(n == 400);
    dav = 1'b1;
    for (n = 0; n < 400 && !ndac_n; n++) step();
    stalls += int'(n == 400);
    {dav, eoi, dio} = '0;
  endtask
  // Acceptor side, used while the device talks
  task automatic recv(output logic [7:0] b, output logic e);
    int n;
    step();
    ndac = 1'b1;
    nrfd = 1'b0;
    for (n = 0; n < 400 && dav_n; n++) step();
    stalls += int'(n == 400);
    b = ~dio_n;
    e = ~eoi_n;
    nrfd = 1'b1;
    ndac = 1'b0;
    for (n = 0; n < 400 && !dav_n; n++) step();
    stalls += int'(n == 400);
    {nrfd, ndac} = '0;
  endtask
endmodule // gbcd_ctrl_model

// ==== test/gbcd_decoder_tb.sv ====
`timescale 1ns/1ps
module gbcd_decoder_tb;
  logic        clk, srst, lock_cfg, local_key, svc_req, eb;
  logic        tx_valid, tx_last, tx_ready, rx_valid, rx_end, rx_ready;
  logic        remote, lockout, panel_locked, listener, talker;
  logic        spoll_mode, dev_clear, trigger;
  logic        atn_n, ifc_n, ren_n, eoi_n, dav_n, nrfd_n, ndac_n, srq_n;
  logic        eoi_oe, dav_oe, nrfd_oe, ndac_oe, srq_oe;
  logic [7:0]  dio_n, dio_oe, status_byte, tx_data, rx_data, rb, mla, mta;
  logic [7:0]  d[4];
  logic [4:0]  prim_addr;
  logic [5:0]  lv;
  logic [10:0] got;
  logic [10:0] expq[$];
  int          err_count, checks;

  gbcd_decoder i_gbcd_decoder (.clk, .srst, .atn_n, .ifc_n, .ren_n,
    .eoi_n_i(eoi_n), .eoi_n_o(), .eoi_oe, .dav_n_i(dav_n), .dav_n_o(),
    .dav_oe, .nrfd_n_i(nrfd_n), .nrfd_n_o(), .nrfd_oe, .ndac_n_i(ndac_n),
    .ndac_n_o(), .ndac_oe, .dio_n_i(dio_n), .dio_n_o(), .dio_oe,
    .srq_n_o(), .srq_oe, .prim_addr, .lock_cfg, .local_key, .svc_req,
    .status_byte, .tx_valid, .tx_data, .tx_last, .tx_ready, .rx_valid,
    .rx_data, .rx_end, .rx_ready, .remote, .lockout, .panel_locked,
    .listener, .talker, .spoll_mode, .dev_clear, .trigger);

  gbcd_ctrl_model i_gbcd_ctrl_model (.clk, .eoi_oe, .dav_oe, .nrfd_oe,
    .ndac_oe, .srq_oe, .dio_oe, .atn_n, .ifc_n, .ren_n, .eoi_n, .dav_n,
    .nrfd_n, .ndac_n, .srq_n, .dio_n);

  assign lv = {remote, lockout, panel_locked, listener, talker, spoll_mode};

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk_lv(input logic [5:0] e);
    chk({5'h00, lv}, {5'h00, e});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic cmd(input logic [7:0] b);
    i_gbcd_ctrl_model.send(b, 1'b0);
    tick(3);
  endtask

  // Valid stays up between bytes, so it is never lowered and raised at once
  task automatic tx_send(input logic [7:0] b, input logic last);
    int n;
    tx_valid <= 1'b1;
    tx_data  <= b;
    tx_last  <= last;
    for (n = 0; n < 400; n++) begin
      @(negedge clk);
      if (tx_ready) break;
    end
    @(posedge clk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Random stalls on the parser side
  always @(posedge clk) rx_ready <= ($urandom % 4) != 0;

  // Results are looked at mid-cycle, where they have settled
  always @(negedge clk) begin
    if (!srst && ((rx_valid && rx_ready) || dev_clear || trigger)) begin
      got = {dev_clear, trigger, rx_valid & rx_end, rx_data & {8{rx_valid}}};
      if (expq.size() == 0) expq.push_back(11'h7FF);
      chk(got, expq.pop_front());
    end
  end

  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end

  initial begin
    prim_addr = 5'($urandom(32'hB6C1) % 31);
    status_byte = 8'($urandom);
    foreach (d[i]) d[i] = 8'($urandom);
    {srst, lock_cfg, local_key, svc_req, tx_valid, tx_last} = 6'h30;
    tx_data = 8'h00;
    rx_ready = 1'b1;
    err_count = 0;
    checks = 0;
    mla = {3'h1, prim_addr};
    mta = {3'h2, prim_addr};
    tick(12);
    srst <= 1'b0;
    tick(3);
    chk_lv(6'h00);
    i_gbcd_ctrl_model.ren <= 1'b1;
    tick(4);
    chk_lv(6'h28);
    i_gbcd_ctrl_model.atn <= 1'b1;
    cmd(mla);
    chk_lv(6'h2C);
    cmd({3'h3, prim_addr});
    chk_lv(6'h2C);
    expq.push_back(11'h400);
    cmd(8'h04);
    i_gbcd_ctrl_model.atn <= 1'b0;
    foreach (d[i]) begin
      expq.push_back({2'h0, i == 3, d[i]});
      i_gbcd_ctrl_model.send(d[i], i == 3);
    end
    i_gbcd_ctrl_model.atn <= 1'b1;
    cmd(8'h3F);
    chk_lv(6'h28);
    cmd(8'h04);
    expq.push_back(11'h400);
    cmd(8'h14);
    expq.push_back(11'h200);
    cmd(8'h08);
    cmd(8'h11);
    chk_lv(6'h38);
    local_key <= 1'b1;
    tick(1);
    local_key <= 1'b0;
    tick(4);
    chk_lv(6'h38);
    cmd(mla);
    cmd(8'h01);
    chk_lv(6'h14);
    cmd(8'h3F);
    svc_req <= 1'b1;
    tick(2);
    chk(11'(srq_n), 11'h000);
    cmd(mta);
    cmd(8'h18);
    chk_lv(6'h13);
    i_gbcd_ctrl_model.atn <= 1'b0;
    i_gbcd_ctrl_model.recv(rb, eb);
    chk({2'h0, eb, rb}, {3'h0, status_byte | 8'h40});
    tick(4);
    chk(11'(srq_n), 11'h001);
    i_gbcd_ctrl_model.atn <= 1'b1;
    cmd(8'h19);
    chk_lv(6'h12);
    i_gbcd_ctrl_model.atn <= 1'b0;
    fork
      begin
        foreach (d[i]) tx_send(~d[i], i == 3);
        tx_valid <= 1'b0;
      end
      foreach (d[i]) begin
        i_gbcd_ctrl_model.recv(rb, eb);
        chk({2'h0, eb, rb}, {2'h0, i == 3, ~d[i]});
      end
    join
    i_gbcd_ctrl_model.atn <= 1'b1;
    cmd(8'h5F);
    chk_lv(6'h10);
    cmd(mla);
    chk_lv(6'h3C);
    i_gbcd_ctrl_model.ifc <= 1'b1;
    tick(4);
    i_gbcd_ctrl_model.ifc <= 1'b0;
    tick(4);
    chk_lv(6'h38);
    chk(11'(expq.size()), 11'h000);
    chk(11'(i_gbcd_ctrl_model.stalls), 11'h000);
    tally_and_finish();
  end
endmodule // gbcd_decoder_tb
